/* inc/bst_map.svh */
/*
 * Register map and timing constants of the swap/trim register bank.
 * Assumes a 32-bit classic Wishbone slave: byte address = 4 * register index.
 */
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

// ****************************************
// Register indexes (byte address = 4 * index)
// ****************************************
`define BST_IDX_TRIM_A   10'h07e
`define BST_IDX_TRIM_B   10'h07f
`define BST_IDX_TRIM_C   10'h080
`define BST_IDX_TRIM_D   10'h081
`define BST_IDX_OVERLAP  10'h09a
`define BST_IDX_STEER    10'h09b

// ****************************************
// Fields and reset values
// ****************************************
`define BST_TRIM_W       8
`define BST_DLY_W        5
`define BST_TRIM_RST     8'h00
`define BST_OVERLAP_RST  5'h08
`define BST_STEER_RST    5'h07

// ****************************************
// Swap timing base, in converter clock cycles, and unmapped slot code
// ****************************************
`define BST_OVL_BASE     7'h04
`define BST_SLOT_NONE    3'h7

`endif

/* inc/bst_pkg.sv */
/*
 * Types and shared arithmetic of the swap/trim register bank.
 * Assumes bst_map.svh is on the include path.
 */
`include "bst_map.svh"
`default_nettype none

package bst_pkg;

   typedef enum logic [1:0] {
      st_idle    = 2'b00,
      st_overlap = 2'b01,
      st_finish  = 2'b11
   } bst_state_t;

   // Dual-sampling length: base plus twice the overlap field
   function automatic logic [6:0] overlap_len(input logic [4:0] dly);
      overlap_len = `BST_OVL_BASE + {1'b0, dly, 1'b0};
   endfunction

endpackage

`default_nettype wire

/* rtl/bst_swap_seq.sv */
/*
 * Background core swap sequencer: dual-sampling window and steering switch.
 * Assumes i_clk_sys is the converter clock and i_swap_req a same-clock pulse.
 */
`include "bst_map.svh"
`default_nettype none

module bst_swap_seq (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic       i_swap_req,
   input  wire logic [4:0] i_overlap_dly,
   input  wire logic [4:0] i_steer_dly,
   output logic            o_swap_busy,
   output logic            o_dual_sample,
   output logic            o_steer_sel
);

   bst_pkg::bst_state_t state;
   bst_pkg::bst_state_t next_state;
   logic [6:0]          cnt;
   logic [6:0]          next_cnt;
   logic [6:0]          len;
   logic [6:0]          next_len;
   logic [6:0]          sw;
   logic [6:0]          next_sw;
   logic                next_steer_sel;
   logic [6:0]          req_len;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_len       = len;
      next_sw        = sw;
      next_steer_sel = o_steer_sel;
      req_len        = bst_pkg::overlap_len(i_overlap_dly);
      case (state)
         bst_pkg::st_idle: begin
            if (i_swap_req) begin
               next_state = bst_pkg::st_overlap;
               next_cnt   = 7'h00;
               next_len   = req_len;
               // Switch lands strictly inside the dual window
               if ({2'h0, i_steer_dly} < req_len - 7'h01) begin
                  next_sw = {2'h0, i_steer_dly};
               end else begin
                  next_sw = req_len - 7'h02;
               end
            end
         end
         bst_pkg::st_overlap: begin
            next_cnt = cnt + 7'h01;
            if (cnt == sw) begin
               next_steer_sel = ~o_steer_sel;
            end
            if (cnt == len - 7'h01) begin
               next_state = bst_pkg::st_finish;
            end
         end
         bst_pkg::st_finish: begin
            next_state = bst_pkg::st_idle;
         end
         default: begin
            next_state = bst_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state       <= bst_pkg::st_idle;
         cnt         <= 7'h00;
         len         <= 7'h00;
         sw          <= 7'h00;
         o_steer_sel <= 1'b0;
      end else begin
         state       <= next_state;
         cnt         <= next_cnt;
         len         <= next_len;
         sw          <= next_sw;
         o_steer_sel <= next_steer_sel;
      end
   end

   assign o_swap_busy   = (state != bst_pkg::st_idle);
   assign o_dual_sample = (state == bst_pkg::st_overlap);

   // ****************************************
   // Checks
   // ****************************************
   ovl_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == bst_pkg::st_idle) && i_swap_req |=>
         o_dual_sample && (len == bst_pkg::overlap_len($past(i_overlap_dly))))
      else $error("swap window length not taken from overlap delay");

   ovl_end_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $fell(o_dual_sample) |-> ($past(cnt) == len - 7'h01))
      else $error("dual sampling window ended at wrong count");

   steer_win_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $changed(o_steer_sel) |-> o_dual_sample && (cnt != 7'h00))
      else $error("steering switched outside dual window");

   steer_time_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $changed(o_steer_sel) |-> (cnt == sw + 7'h01))
      else $error("steering switched at wrong delay");

endmodule

`default_nettype wire

/* rtl/bst_regs.sv */
/*
 * Swap/trim configuration register bank with classic Wishbone slave port.
 * Assumes factory trim inputs are stable logic on i_clk_sys and swap
 * requests come from the calibration engine on the same clock.
 */
// Overview of operation
// - Four 8-bit trim registers load factory values after reset, read/write.
// - Swap dual-sampling lasts four plus twice overlap value, converter cycles.
// - Overlap delay is 5-bit read/write field, bits 4:0, reset eight.
// - Steering delay is added to output select, only during a swap.
// - Steering delay is 5-bit read/write field, reset seven.
`include "bst_map.svh"
`default_nettype none

module bst_regs (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [11:0] i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic [7:0]  i_fuse_trim_a,
   input  wire logic [7:0]  i_fuse_trim_b,
   input  wire logic [7:0]  i_fuse_trim_c,
   input  wire logic [7:0]  i_fuse_trim_d,
   output logic      [7:0]  o_term_trim_a,
   output logic      [7:0]  o_term_trim_b,
   output logic      [7:0]  o_term_trim_c,
   output logic      [7:0]  o_term_trim_d,
   input  wire logic        i_swap_req,
   output logic             o_swap_busy,
   output logic             o_dual_sample,
   output logic             o_steer_sel
);

   logic [7:0]  trim [4];
   logic [7:0]  next_trim [4];
   logic [4:0]  overlap_dly;
   logic [4:0]  next_overlap_dly;
   logic [4:0]  steer_dly;
   logic [4:0]  next_steer_dly;
   logic        load_pending;
   logic        next_load_pending;
   logic        next_ack;
   logic [31:0] next_dat;
   logic        req;
   logic [2:0]  slot;

   // ****************************************
   // Address decode
   // ****************************************
   // Slot 0..3 trims, 4 overlap, 5 steering, else unmapped
   function automatic logic [2:0] reg_slot(input logic [11:0] adr);
      case (adr[11:2])
         `BST_IDX_TRIM_A:  reg_slot = 3'h0;
         `BST_IDX_TRIM_B:  reg_slot = 3'h1;
         `BST_IDX_TRIM_C:  reg_slot = 3'h2;
         `BST_IDX_TRIM_D:  reg_slot = 3'h3;
         `BST_IDX_OVERLAP: reg_slot = 3'h4;
         `BST_IDX_STEER:   reg_slot = 3'h5;
         default:          reg_slot = `BST_SLOT_NONE;
      endcase
   endfunction

   assign req  = i_wb_cyc & i_wb_stb;
   assign slot = reg_slot(i_wb_adr);

   // ****************************************
   // Register file and bus slave
   // ****************************************
   always_comb begin
      next_trim         = trim;
      next_overlap_dly  = overlap_dly;
      next_steer_dly    = steer_dly;
      next_load_pending = 1'b0;
      next_dat          = o_wb_dat;
      // No request taken until factory values are in
      next_ack          = req & ~o_wb_ack & ~load_pending;
      if (next_ack) begin
         case (slot)
            3'h0, 3'h1, 3'h2, 3'h3: begin
               next_dat = {24'h000000, trim[slot[1:0]]};
            end
            3'h4: begin
               next_dat = {27'h0000000, overlap_dly};
            end
            3'h5: begin
               next_dat = {27'h0000000, steer_dly};
            end
            default: begin
               next_dat = 32'h00000000;
            end
         endcase
      end
      if (load_pending) begin
         next_trim[0] = i_fuse_trim_a;
         next_trim[1] = i_fuse_trim_b;
         next_trim[2] = i_fuse_trim_c;
         next_trim[3] = i_fuse_trim_d;
      end else if (req & o_wb_ack & i_wb_we & i_wb_sel[0]) begin
         case (slot)
            3'h0, 3'h1, 3'h2, 3'h3: begin
               next_trim[slot[1:0]] = i_wb_dat[7:0];
            end
            3'h4: begin
               // Reserved bits 7:5 are not stored
               next_overlap_dly = i_wb_dat[4:0];
            end
            3'h5: begin
               next_steer_dly = i_wb_dat[4:0];
            end
            default: begin
               next_overlap_dly = overlap_dly;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < 4; i++) begin
            trim[i] <= `BST_TRIM_RST;
         end
         overlap_dly  <= `BST_OVERLAP_RST;
         steer_dly    <= `BST_STEER_RST;
         load_pending <= 1'b1;
         o_wb_ack     <= 1'b0;
         o_wb_dat     <= 32'h00000000;
      end else begin
         trim         <= next_trim;
         overlap_dly  <= next_overlap_dly;
         steer_dly    <= next_steer_dly;
         load_pending <= next_load_pending;
         o_wb_ack     <= next_ack;
         o_wb_dat     <= next_dat;
      end
   end

   assign o_term_trim_a = trim[0];
   assign o_term_trim_b = trim[1];
   assign o_term_trim_c = trim[2];
   assign o_term_trim_d = trim[3];

   // ****************************************
   // Swap sequencer
   // ****************************************
   bst_swap_seq u_swap_seq (
      .i_clk_sys     (i_clk_sys),
      .i_rst         (i_rst),
      .i_swap_req    (i_swap_req),
      .i_overlap_dly (overlap_dly),
      .i_steer_dly   (steer_dly),
      .o_swap_busy   (o_swap_busy),
      .o_dual_sample (o_dual_sample),
      .o_steer_sel   (o_steer_sel)
   );

   // ****************************************
   // Checks
   // ****************************************
   trim_load_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      load_pending |=> (o_term_trim_a == $past(i_fuse_trim_a)) && (o_term_trim_d == $past(i_fuse_trim_d))
         && !load_pending)
      else $error("factory trim not loaded after reset");

   trim_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      req && o_wb_ack && i_wb_we && i_wb_sel[0] && !load_pending && (i_wb_adr[11:2] == `BST_IDX_TRIM_C)
         |=> (o_term_trim_c == $past(i_wb_dat[7:0])))
      else $error("trim write not stored");

   dly_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      load_pending |-> (overlap_dly == 5'h08) && (steer_dly == 5'h07))
      else $error("delay reset values wrong");

   ovl_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      req && o_wb_ack && i_wb_we && i_wb_sel[0] && (i_wb_adr[11:2] == `BST_IDX_OVERLAP)
         |=> (overlap_dly == $past(i_wb_dat[4:0])))
      else $error("overlap delay write not stored");

   steer_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      req && !o_wb_ack && !load_pending && !i_wb_we && (i_wb_adr[11:2] == `BST_IDX_STEER)
         |=> o_wb_ack && (o_wb_dat == {27'h0000000, $past(steer_dly)}))
      else $error("steering delay readback wrong");

   ack_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

/* sim/tb_top.sv */
/*
 * Self-checking bench of the swap/trim register bank.
 * Assumes bst_map.svh on the include path and bst_regs as the top design.
 */
`include "bst_map.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic        i_clk_sys = 1'b0;
   logic        i_rst     = 1'b1;
   logic        i_wb_cyc  = 1'b0;
   logic        i_wb_stb  = 1'b0;
   logic        i_wb_we   = 1'b0;
   logic [11:0] i_wb_adr  = 12'h000;
   logic [3:0]  i_wb_sel  = 4'h0;
   logic [31:0] i_wb_dat  = 32'h0;
   logic [31:0] o_wb_dat;
   logic        o_wb_ack;
   logic [7:0]  fuse [4]  = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
   logic [7:0]  trim [4];
   logic        i_swap_req = 1'b0;
   logic        o_swap_busy;
   logic        o_dual_sample;
   logic        o_steer_sel;
   logic [11:0] trim_adr [4] = '{{`BST_IDX_TRIM_A, 2'b00}, {`BST_IDX_TRIM_B, 2'b00},
                                 {`BST_IDX_TRIM_C, 2'b00}, {`BST_IDX_TRIM_D, 2'b00}};
   logic [11:0] ovl_adr   = {`BST_IDX_OVERLAP, 2'b00};
   logic [11:0] steer_adr = {`BST_IDX_STEER, 2'b00};
   int          fails     = 0;
   int          num_checks = 0;
   int          cycles    = 0;
   logic        steer_exp = 1'b0;

   bst_regs u_dut (
      .i_clk_sys     (i_clk_sys),
      .i_rst         (i_rst),
      .i_wb_cyc      (i_wb_cyc),
      .i_wb_stb      (i_wb_stb),
      .i_wb_we       (i_wb_we),
      .i_wb_adr      (i_wb_adr),
      .i_wb_sel      (i_wb_sel),
      .i_wb_dat      (i_wb_dat),
      .o_wb_dat      (o_wb_dat),
      .o_wb_ack      (o_wb_ack),
      .i_fuse_trim_a (fuse[0]),
      .i_fuse_trim_b (fuse[1]),
      .i_fuse_trim_c (fuse[2]),
      .i_fuse_trim_d (fuse[3]),
      .o_term_trim_a (trim[0]),
      .o_term_trim_b (trim[1]),
      .o_term_trim_c (trim[2]),
      .o_term_trim_d (trim[3]),
      .i_swap_req    (i_swap_req),
      .o_swap_busy   (o_swap_busy),
      .o_dual_sample (o_dual_sample),
      .o_steer_sel   (o_steer_sel)
   );

   always #25 i_clk_sys = ~i_clk_sys;

   // ****************************************
   // Reporting
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run();
      end
   end

   // ****************************************
   // Classic Wishbone single cycle
   // ****************************************
   task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                     input logic sel0, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= we;
      i_wb_adr <= adr;
      i_wb_dat <= wd;
      i_wb_sel <= {3'b000, sel0};
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 50);
      // A missing acknowledge counts as a mismatch
      if (o_wb_ack !== 1'b1) begin
         fails++;
         $display("BAD wb ack expected 1 seen %b", o_wb_ack);
      end
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we  <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [11:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb(1'b0, adr, 32'h0, 1'b1, rd);
      chk(what, exp, rd);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_values();
      logic [31:0] rd;
      for (int i = 0; i < 4; i++) begin
         chk("trim out after reset", {24'h0, fuse[i]}, {24'h0, trim[i]});
         rd_chk("trim read after reset", trim_adr[i], {24'h0, fuse[i]});
      end
      rd_chk("overlap reset", ovl_adr, 32'h08);
      rd_chk("steer reset", steer_adr, 32'h07);
   endtask

   task automatic trim_rw();
      logic [31:0] rd;
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, trim_adr[i], {24'hffffff, 8'h81 + 8'(i)}, 1'b1, rd);
         rd_chk("trim readback", trim_adr[i], {24'h0, 8'h81 + 8'(i)});
         chk("trim out", {24'h0, 8'h81 + 8'(i)}, {24'h0, trim[i]});
      end
      wb(1'b1, trim_adr[0], 32'h00, 1'b0, rd);
      rd_chk("trim sel0 low", trim_adr[0], 32'h81);
      wb(1'b1, 12'h100, 32'hff, 1'b1, rd);
      rd_chk("unmapped", 12'h100, 32'h0);
   endtask

   task automatic delay_fields();
      logic [31:0] rd;
      wb(1'b1, ovl_adr, 32'h1f, 1'b1, rd);
      rd_chk("overlap max", ovl_adr, 32'h1f);
      wb(1'b1, steer_adr, 32'h00, 1'b1, rd);
      rd_chk("steer zero", steer_adr, 32'h00);
      wb(1'b1, steer_adr, 32'h1f, 1'b1, rd);
      rd_chk("steer max", steer_adr, 32'h1f);
   endtask

   task automatic swap(input logic [4:0] n, input logic [4:0] d);
      logic [31:0] rd;
      logic        s0;
      int          len;
      int          flip;
      int          exp_l;
      int          exp_s;
      exp_l = 4 + 2 * int'(n);
      exp_s = (int'(d) < exp_l - 1) ? int'(d) : exp_l - 2;
      wb(1'b1, ovl_adr, {27'h0, n}, 1'b1, rd);
      wb(1'b1, steer_adr, {27'h0, d}, 1'b1, rd);
      @(posedge i_clk_sys);
      i_swap_req <= 1'b1;
      @(posedge i_clk_sys);
      i_swap_req <= 1'b0;
      #1;
      s0 = o_steer_sel;
      len = 0;
      flip = -1;
      chk("steer idle", {31'h0, steer_exp}, {31'h0, s0});
      steer_exp = ~steer_exp;
      while (o_dual_sample === 1'b1 && len < 100) begin
         if (o_steer_sel !== s0 && flip < 0) flip = len;
         if (len == 2) i_swap_req <= 1'b1;
         @(posedge i_clk_sys);
         i_swap_req <= 1'b0;
         len++;
         #1;
      end
      chk("dual length", 32'(exp_l), 32'(len));
      chk("steer flip", 32'(exp_s + 1), 32'(flip));
      chk("finish busy", 32'h1, {31'h0, o_swap_busy});
      @(posedge i_clk_sys);
      #1;
      chk("idle busy", 32'h0, {31'h0, o_swap_busy});
      chk("dual after", 32'h0, {31'h0, o_dual_sample});
      chk("steer after", {31'h0, steer_exp}, {31'h0, o_steer_sel});
   endtask

   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      reset_values();
      trim_rw();
      delay_fields();
      swap(5'h08, 5'h07);
      swap(5'h00, 5'h1f);
      swap(5'h07, 5'h00);
      swap(5'h1f, 5'h1f);
      complete_run();
   end
endmodule

`default_nettype wire
